/* src/irq_pkg.sv */
package irq_pkg;
	// ****************************************
	// Sources, in default query order
	// ****************************************
	localparam int NSRC = 13;
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_T0 = 4'h1;
	localparam logic [3:0] SRC_EXT1 = 4'h2;
	localparam logic [3:0] SRC_T1 = 4'h3;
	localparam logic [3:0] SRC_EXT2 = 4'h4;
	localparam logic [3:0] SRC_TWI = 4'h5;
	localparam logic [3:0] SRC_ADC = 4'h6;
	localparam logic [3:0] SRC_CSU = 4'h7;
	localparam logic [3:0] SRC_SHR = 4'h8;
	localparam logic [3:0] SRC_WDT = 4'h9;
	localparam logic [3:0] SRC_LVD = 4'ha;
	localparam logic [3:0] SRC_UA0 = 4'hb;
	localparam logic [3:0] SRC_UA1 = 4'hc;
	localparam logic [3:0] SRC_PD = 4'hd;
	localparam logic [15:0] RESET_VEC = 16'h0000;
	localparam logic [15:0] VEC_TABLE [0:12] = '{16'h0003, 16'h000b, 16'h0013,
		16'h001b, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b, 16'h0073,
		16'h007b, 16'h0083, 16'h008b};
	localparam logic [12:0] WAKE_MASK = 13'h0235;
	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_TFLAG = 8'h88;
	localparam logic [7:0] IDX_EN0 = 8'ha8;
	localparam logic [7:0] IDX_PRI0 = 8'hb8;
	localparam logic [7:0] IDX_FLAG2 = 8'he1;
	localparam logic [7:0] IDX_EN1 = 8'he6;
	localparam logic [7:0] IDX_EN2 = 8'he7;
	localparam logic [7:0] IDX_FLAG1 = 8'hf1;
	localparam logic [7:0] IDX_PRI2 = 8'hf4;
	localparam logic [7:0] IDX_PRI1 = 8'hf6;
	localparam logic [7:0] IDX_XCFG = 8'h40;
	localparam logic [7:0] IDX_STAT = 8'h41;
	// Field positions
	localparam int GLOBAL_BIT = 7;
	localparam int TF_EXT0 = 1;
	localparam int TF_EXT1 = 3;
	localparam int TF_T0 = 5;
	localparam int TF_T1 = 7;
	localparam int XCFG_PDEN = 8;
	localparam int XCFG_PDFLAG = 9;
	localparam logic [7:0] MODE_RST = 8'h55;
	// ****************************************
	// Timing, in instruction cycles (one clock each)
	// ****************************************
	localparam int CLK_PER_INSTR = 1;
	localparam int DETECT_INSTR = 1;
	localparam int LCALL_INSTR = 4;
	localparam int LCALL_CYCLES = LCALL_INSTR * CLK_PER_INSTR;
	localparam logic [2:0] LCALL_LAST = 3'(LCALL_CYCLES - 1);
	localparam int MIN_LAT_INSTR = DETECT_INSTR + LCALL_INSTR;
	localparam int MAX_LAT_INSTR = 13;
	// Levels
	localparam logic [1:0] LVL_LOW = 2'd0;
	localparam logic [1:0] LVL_HIGH = 2'd1;
	localparam logic [1:0] LVL_TOP = 2'd2;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CALL = 2'b10} ctl_state_t;
endpackage

/* src/two_level_interrupt_controller.sv */
// Notes on behaviour
// [RL1] After reset, fetching starts at program address zero.
// [RL2] A taken request branches to its source's fixed service address.
// [RL3] Pin interrupt 0: own flag, enable bit 0, vector 0x0003, rank 1, wakes.
// [RL4] Pin interrupt 1: enable bit 2, priority bit 2, vector 0x0013, rank 3, wakes.
// [RL5] Pin interrupt 2: second enable bit 2, vector 0x004B, rank 5, wakes.
// [RL6] Shared pin interrupt: second enable bit 6, vector 0x006B, rank 9, no wake.
// [RL7] Two-wire slave done: second enable bit 3, vector 0x0053, rank 6, wakes.
// [RL8] A started routine runs to the end unless a higher level preempts.
// [RL9] Return resumes the interrupted code and restores the prior level state.
// [RL10] Low routines yield only to high; equal or lower waits for return.
// [RL11] Accept after the instruction ends; after return or control access, one more.
// [RL12] Each source has high or low level; equal level picks smallest rank.
// [RL13] High level requests are served before any low level request.
// [RL14] Enabled power-down interrupt is the sole level above high.
// [RL15] Peripherals request by setting flags that the controller evaluates.
// [RL16] Pins are sampled at the end of the first clock of an instruction.
// [RL17] Pin sources hold each level at least two clocks.
// [RL18] Least latency: one detect cycle plus four for the long call.
// [RL19] Worst latency is 13 instruction cycles after return then multiply.
// [RL20] Hardware sets flags; only software clears them, never on entry.
// [RL21] Global enable masks all requests; when set each enable governs.
// [RL22] Other sources use fixed addresses and ranks; only watchdog wakes.
// [RL23] Pending only with flag, own enable and global enable all set.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module two_level_interrupt_controller #(
	parameter logic [15:0] PD_VECTOR = 16'h0093
) (
	// Clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [irq_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// External pins
	input wire logic i_ext_pin_irq_0,
	input wire logic i_ext_pin_irq_1,
	input wire logic i_ext_pin_irq_2,
	input wire logic i_shared_ext_irq,
	// Peripheral event pulses
	input wire logic i_timer0_set,
	input wire logic i_timer1_set,
	input wire logic i_twowire_set,
	input wire logic i_adc_set,
	input wire logic i_capsense_set,
	input wire logic i_wdt_tmr2_set,
	input wire logic i_lvdt_set,
	input wire logic i_uart0_set,
	input wire logic i_uart1_set,
	input wire logic i_pwrdown_set,
	// Core handshake
	input wire logic i_first_instr_clock,
	input wire logic i_instr_done,
	input wire logic i_instr_reti,
	output logic o_call,
	output logic [15:0] o_call_vector,
	output logic [2:0] o_active_level,
	output logic o_wake
);
	import irq_pkg::*;

	// The power-down target must differ from the boot branch, else the core cannot tell them apart
	if (PD_VECTOR == RESET_VEC) begin : g_bad_pd_vector
		$error("PD_VECTOR must not be the boot address");
	end

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic is_mapped(input logic [7:0] idx);
		case (idx)
			IDX_TFLAG, IDX_EN0, IDX_PRI0, IDX_FLAG2, IDX_EN1, IDX_EN2,
			IDX_FLAG1, IDX_PRI2, IDX_PRI1, IDX_XCFG, IDX_STAT: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic is_ctl(input logic [7:0] idx);
		case (idx)
			IDX_EN0, IDX_EN1, IDX_EN2, IDX_PRI0, IDX_PRI1, IDX_PRI2: is_ctl = 1'b1;
			default: is_ctl = 1'b0;
		endcase
	endfunction

	// Returns {valid, level, source}; lower index wins within a level
	function automatic logic [6:0] pick(input logic [NSRC:0] p,
		input logic [NSRC-1:0] pri);
		logic [6:0] hi;
		logic [6:0] lo;
		hi = '0;
		lo = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (p[i] && pri[i]) begin
				hi = {1'b1, LVL_HIGH, 4'(i)};
			end
			if (p[i] && !pri[i]) begin
				lo = {1'b1, LVL_LOW, 4'(i)};
			end
		end
		if (p[NSRC]) begin
			pick = {1'b1, LVL_TOP, SRC_PD}; // RL14
		end else if (hi[6]) begin
			pick = hi; // RL13
		end else begin
			pick = lo; // RL12
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic [NSRC-1:0] flag_r;
	logic [NSRC-1:0] en_r;
	logic [NSRC-1:0] pri_r;
	logic global_en_r;
	logic pd_en_r;
	logic pd_flag_r;
	logic [7:0] mode_r;
	logic [NSRC:0] pend_r;
	logic [3:0] last_src_r;
	ctl_state_t state_r;
	logic [2:0] call_cnt_r;
	logic ctl_touch_r;
	logic [3:0] pin_s1_r;
	logic [3:0] pin_s2_r;
	logic [3:0] pin_s3_r;
	logic [3:0] pin_lvl_r;
	logic [3:0] pin_samp_r;

	// ****************************************
	// APB decode
	// ****************************************
	logic [7:0] idx;
	logic addr_ok;
	logic apb_fire;
	logic wr;
	assign idx = i_paddr[9:2];
	assign addr_ok = (i_paddr[ADDR_W-1:10] == '0) && (i_paddr[1:0] == 2'b00) && is_mapped(idx);
	assign apb_fire = i_psel && i_penable && o_pready;
	assign wr = apb_fire && i_pwrite && addr_ok;

	// Answer on the second access cycle so read data comes from a flop
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_pready <= 1'b0;
		end else if (i_ce) begin
			o_pready <= i_psel && i_penable && !o_pready;
		end
	end

	// Read data and error, captured on the same edge that raises ready
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else if (i_ce && i_psel && i_penable && !o_pready) begin
			o_pslverr <= !addr_ok;
			o_prdata <= '0;
			if (!i_pwrite && addr_ok) begin
				case (idx)
					IDX_TFLAG: o_prdata[7:0] <= {flag_r[SRC_T1], 1'b0, flag_r[SRC_T0], 1'b0,
						flag_r[SRC_EXT1], 1'b0, flag_r[SRC_EXT0], 1'b0};
					IDX_EN0: o_prdata[7:0] <= {global_en_r, 3'b000, en_r[3:0]};
					IDX_PRI0: o_prdata[7:0] <= {4'h0, pri_r[3:0]};
					IDX_FLAG1: o_prdata[7:0] <= {flag_r[9:4], 2'b00};
					IDX_EN1: o_prdata[7:0] <= {en_r[9:4], 2'b00};
					IDX_PRI1: o_prdata[7:0] <= {pri_r[9:4], 2'b00};
					IDX_FLAG2: o_prdata[7:0] <= {5'h00, flag_r[12:10]};
					IDX_EN2: o_prdata[7:0] <= {5'h00, en_r[12:10]};
					IDX_PRI2: o_prdata[7:0] <= {5'h00, pri_r[12:10]};
					IDX_XCFG: o_prdata[9:0] <= {pd_flag_r, pd_en_r, mode_r};
					IDX_STAT: o_prdata[9:0] <= {state_r, o_active_level, pend_r[NSRC], last_src_r};
					default: o_prdata <= '0;
				endcase
			end
		end
	end

	// ****************************************
	// Pin synchronisers and sampling
	// ****************************************
	logic [3:0] pins;
	logic [3:0] pin_ev;
	assign pins = {i_shared_ext_irq, i_ext_pin_irq_2, i_ext_pin_irq_1, i_ext_pin_irq_0};

	// Filtered level moves only when the two late stages agree
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			pin_lvl_r <= '0;
		end else if (i_ce) begin
			pin_s1_r <= pins;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_lvl_r <= (pin_s2_r & pin_s3_r) | (pin_lvl_r & (pin_s2_r | pin_s3_r)); // RL17
		end
	end

	// Edges count only between first-clock samples
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pin_samp_r <= '0;
		end else if (i_ce && i_first_instr_clock) begin
			pin_samp_r <= pin_lvl_r; // RL16
		end
	end

	// Mode: even bit rising, odd bit falling
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_edge
			assign pin_ev[g] = i_first_instr_clock &&
				((mode_r[2*g] && pin_lvl_r[g] && !pin_samp_r[g]) ||
				(mode_r[2*g+1] && !pin_lvl_r[g] && pin_samp_r[g])); // RL16
		end
	endgenerate

	// ****************************************
	// Request flags
	// ****************************************
	logic [NSRC-1:0] set_v;
	logic [NSRC-1:0] wmask;
	logic [NSRC-1:0] wval;

	// Event inputs per source
	always_comb begin
		set_v = '0;
		set_v[SRC_EXT0] = pin_ev[0]; // RL3
		set_v[SRC_EXT1] = pin_ev[1]; // RL4
		set_v[SRC_EXT2] = pin_ev[2]; // RL5
		set_v[SRC_SHR] = pin_ev[3]; // RL6
		set_v[SRC_TWI] = i_twowire_set; // RL7
		set_v[SRC_T0] = i_timer0_set; // RL15
		set_v[SRC_T1] = i_timer1_set;
		set_v[SRC_ADC] = i_adc_set;
		set_v[SRC_CSU] = i_capsense_set;
		set_v[SRC_WDT] = i_wdt_tmr2_set; // RL22
		set_v[SRC_LVD] = i_lvdt_set;
		set_v[SRC_UA0] = i_uart0_set;
		set_v[SRC_UA1] = i_uart1_set;
	end

	// Software write image of the flags
	always_comb begin
		wmask = '0;
		wval = '0;
		if (wr) begin
			case (idx)
				IDX_TFLAG: begin
					wmask[3:0] = 4'hf;
					wval[SRC_EXT0] = i_pwdata[TF_EXT0];
					wval[SRC_T0] = i_pwdata[TF_T0];
					wval[SRC_EXT1] = i_pwdata[TF_EXT1];
					wval[SRC_T1] = i_pwdata[TF_T1];
				end
				IDX_FLAG1: begin
					wmask[9:4] = 6'h3f;
					wval[9:4] = i_pwdata[7:2];
				end
				IDX_FLAG2: begin
					wmask[12:10] = 3'h7;
					wval[12:10] = i_pwdata[2:0];
				end
				default: wmask = '0;
			endcase
		end
	end

	// A same-cycle event beats a software clear; entry never clears
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			flag_r <= '0;
		end else if (i_ce) begin
			flag_r <= (flag_r & ~wmask) | wval | set_v; // RL20
		end
	end

	// Power-down flag lives in the extra config word
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pd_flag_r <= 1'b0;
		end else if (i_ce) begin
			if (i_pwrdown_set) begin
				pd_flag_r <= 1'b1; // RL20
			end else if (wr && idx == IDX_XCFG) begin
				pd_flag_r <= i_pwdata[XCFG_PDFLAG];
			end
		end
	end

	// ****************************************
	// Enable, priority and config registers
	// ****************************************
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			en_r <= '0;
			global_en_r <= 1'b0;
		end else if (i_ce && wr) begin
			case (idx)
				IDX_EN0: begin
					global_en_r <= i_pwdata[GLOBAL_BIT];
					en_r[3:0] <= i_pwdata[3:0]; // RL3
				end
				IDX_EN1: en_r[9:4] <= i_pwdata[7:2]; // RL5
				IDX_EN2: en_r[12:10] <= i_pwdata[2:0];
				default: en_r <= en_r;
			endcase
		end
	end

	// Level per source: one means high
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pri_r <= '0;
		end else if (i_ce && wr) begin
			case (idx)
				IDX_PRI0: pri_r[3:0] <= i_pwdata[3:0]; // RL4
				IDX_PRI1: pri_r[9:4] <= i_pwdata[7:2]; // RL12
				IDX_PRI2: pri_r[12:10] <= i_pwdata[2:0];
				default: pri_r <= pri_r;
			endcase
		end
	end

	// Pin edge modes and power-down enable
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			mode_r <= MODE_RST;
			pd_en_r <= 1'b0;
		end else if (i_ce && wr && idx == IDX_XCFG) begin
			mode_r <= i_pwdata[7:0];
			pd_en_r <= i_pwdata[XCFG_PDEN]; // RL14
		end
	end

	// ****************************************
	// Detect and arbitrate
	// ****************************************
	// Requests are latched once per instruction: the detect cycle
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pend_r <= '0;
		end else if (i_ce && i_first_instr_clock) begin
			pend_r <= {pd_flag_r && pd_en_r, flag_r & en_r} & {(NSRC+1){global_en_r}}; // RL21 RL23
		end
	end

	logic [6:0] win;
	logic win_valid;
	logic [1:0] win_lvl;
	logic [3:0] win_idx;
	logic [15:0] win_vec;
	logic ctl_now;
	logic special;
	logic accept;
	assign win = pick(pend_r, pri_r);
	assign win_valid = win[6];
	assign win_lvl = win[5:4];
	assign win_idx = win[3:0];
	assign win_vec = (win_idx == SRC_PD) ? PD_VECTOR : VEC_TABLE[win_idx]; // RL2 RL22

	// Control access marks the current instruction as one that defers
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ctl_touch_r <= 1'b0;
		end else if (i_ce) begin
			if (i_instr_done) begin
				ctl_touch_r <= 1'b0;
			end else if (apb_fire && addr_ok && is_ctl(idx)) begin
				ctl_touch_r <= 1'b1;
			end
		end
	end

	// A deferring instruction forces one more to finish, bounding worst latency
	assign ctl_now = apb_fire && addr_ok && is_ctl(idx);
	assign special = i_instr_reti || ctl_touch_r || ctl_now; // RL11 RL19

	// Only a strictly higher level than any running routine may enter
	assign accept = i_ce && state_r == ST_IDLE && i_instr_done && !special && win_valid &&
		((o_active_level & (3'b111 << win_lvl)) == 3'b000); // RL8 RL10

	// ****************************************
	// Nesting and call sequencing
	// ****************************************
	// Return drops the highest running level only
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_active_level <= 3'b000;
		end else if (i_ce) begin
			if (i_instr_done && i_instr_reti) begin
				if (o_active_level[2]) begin
					o_active_level[2] <= 1'b0; // RL9
				end else if (o_active_level[1]) begin
					o_active_level[1] <= 1'b0;
				end else begin
					o_active_level[0] <= 1'b0;
				end
			end else if (accept) begin
				o_active_level <= o_active_level | (3'b001 << win_lvl); // RL10
			end
		end
	end

	// Call pulse; the reset value is the boot branch to zero
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_call <= 1'b1;
			o_call_vector <= RESET_VEC; // RL1
			last_src_r <= '0;
		end else if (i_ce) begin
			o_call <= accept;
			if (accept) begin
				o_call_vector <= win_vec; // RL2
				last_src_r <= win_idx;
			end
		end
	end

	// Long call occupies the core; no new entry meanwhile
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_r <= ST_IDLE;
			call_cnt_r <= '0;
		end else if (i_ce) begin
			case (state_r)
				ST_IDLE: begin
					if (accept) begin
						state_r <= ST_CALL;
						call_cnt_r <= LCALL_LAST; // RL18
					end
				end
				ST_CALL: begin
					if (call_cnt_r == 3'd0) begin
						state_r <= ST_IDLE;
					end else begin
						call_cnt_r <= call_cnt_r - 3'd1;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Wake request from enabled waking sources
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_wake <= 1'b0;
		end else if (i_ce) begin
			o_wake <= global_en_r && |(flag_r & en_r & WAKE_MASK); // RL3 RL6 RL22
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	logic [12:0] lower_same;
	assign lower_same = pend_r[NSRC-1:0] & ((13'h0001 << win_idx) - 13'h0001) &
		((win_lvl == LVL_HIGH) ? pri_r : ~pri_r);

	sequence s_reti_done;
		i_ce && i_instr_done && i_instr_reti;
	endsequence

	sequence s_call_run;
		i_ce[*4];
	endsequence

	a_boot_vector: // RL1
	assert property (@(posedge i_core_clk) $fell(i_sys_rst) |-> o_call && o_call_vector == 16'h0000)
		else $error("boot branch not to zero");

	a_call_vector: // RL2
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		accept |=> o_call && o_call_vector == $past(win_vec))
		else $error("wrong service address");

	a_ext0_entry: // RL3
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		accept && win_idx == 4'h0 |=> o_call_vector == 16'h0003)
		else $error("pin 0 vector wrong");

	a_nest_level: // RL10
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		accept |=> o_active_level >= 3'(2 * $past(o_active_level) + 1))
		else $error("entry not above running level");

	a_reti_restore: // RL9
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		s_reti_done ##0 (o_active_level != 3'b000) |=> !o_call &&
		o_active_level < $past(o_active_level) && (o_active_level & ~$past(o_active_level)) == 3'b000)
		else $error("return did not restore level");

	a_high_first: // RL13
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		accept && win_lvl == LVL_LOW |-> (pend_r[NSRC-1:0] & pri_r) == '0 && !pend_r[NSRC])
		else $error("low taken over high");

	a_rank_order: // RL12
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		accept && win_lvl != LVL_TOP |-> lower_same == '0)
		else $error("rank order broken");

	a_pd_top: // RL14
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		accept && pend_r[NSRC] |-> win_lvl == LVL_TOP && win_idx == SRC_PD)
		else $error("power-down not top");

	a_global_mask: // RL21
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_ce && i_first_instr_clock && !global_en_r |=> pend_r == '0)
		else $error("request passed global mask");

	a_flag_kept: // RL20
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		accept && wmask == '0 |=> (($past(win_idx) == SRC_PD) ? pd_flag_r : flag_r[$past(win_idx)]))
		else $error("flag cleared on entry");

	a_pin_sample: // RL16
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!(i_ce && i_first_instr_clock) |=> $stable(pin_samp_r))
		else $error("pin sampled off first clock");

	a_call_length: // RL18
	assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		accept ##1 s_call_run |=> state_r == ST_IDLE && $past(state_r) == ST_CALL)
		else $error("long call length wrong");

endmodule

/* tb/core_model.sv */
`timescale 1ns/1ps
// ****************************************
// Core stand-in: instruction and return timing
// ****************************************
module core_model (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Bench commands
	input wire logic i_ret_req,
	input wire logic i_slow,
	// Core handshake
	output logic o_first_clk,
	output logic o_done,
	output logic o_reti
);
	logic half_r;
	logic ret_r;
	// Slow mode spreads an instruction over two clocks
	always_ff @(posedge i_core_clk) begin
		half_r <= !i_sys_rst && i_slow && !half_r;
	end
	// A return waits for the end of its own instruction, never lost
	always_ff @(posedge i_core_clk) begin
		ret_r <= !i_sys_rst && (i_ret_req || ret_r) && !o_done;
	end
	assign o_first_clk = !half_r;
	assign o_done = !i_slow || half_r;
	assign o_reti = (i_ret_req || ret_r) && o_done;
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
	import irq_pkg::*;
	// ****************************************
	// Signals and shadow state
	// ****************************************
	localparam logic [15:0] PDV = 16'h0093;
	localparam logic [7:0] FI[3] = '{8'h88, 8'hf1, 8'he1};
	localparam logic [7:0] EI[3] = '{8'ha8, 8'he6, 8'he7};
	localparam logic [7:0] PI[3] = '{8'hb8, 8'hf6, 8'hf4};
	logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, ret = 0, slow = 0, ce = 1;
	logic [11:0] pa = '0;
	logic [31:0] pd = '0, prd, rd, seed = 32'ha861;
	logic [13:0] src = '0;
	logic call, fic, done, reti, rdy, serr, rs, wake;
	logic [15:0] vec;
	logic [2:0] lvl;
	logic [15:0] q[$];
	logic [7:0] en[3], pr[3];
	int err_total = 0, cmp_count = 0, cyc = 0;
	core_model cm (.i_core_clk(clk), .i_sys_rst(rst), .i_ret_req(ret), .i_slow(slow),
		.o_first_clk(fic), .o_done(done), .o_reti(reti));
	two_level_interrupt_controller #(.PD_VECTOR(PDV)) DUT (.i_core_clk(clk), .i_sys_rst(rst),
		.i_ce(ce), .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa),
		.i_pwdata(pd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr),
		.i_ext_pin_irq_0(src[0]), .i_ext_pin_irq_1(src[2]), .i_ext_pin_irq_2(src[4]),
		.i_shared_ext_irq(src[8]), .i_timer0_set(src[1]), .i_timer1_set(src[3]),
		.i_twowire_set(src[5]), .i_adc_set(src[6]), .i_capsense_set(src[7]),
		.i_wdt_tmr2_set(src[9]), .i_lvdt_set(src[10]), .i_uart0_set(src[11]),
		.i_uart1_set(src[12]), .i_pwrdown_set(src[13]), .i_first_instr_clock(fic),
		.i_instr_done(done), .i_instr_reti(reti), .o_call(call), .o_call_vector(vec),
		.o_active_level(lvl), .o_wake(wake));
	// Clock, 8 ns period
	initial forever #4 clk = ~clk;
	// Log every branch order; the cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (!rst && call)
			q.push_back(vec);
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic int grp(input int i);
		return i < 4 ? 0 : (i < 10 ? 1 : 2);
	endfunction
	// Enable and level bit; flag bits of the first group are interleaved
	function automatic int eb(input int i);
		return i < 4 ? i : (i < 10 ? i - 2 : i - 10);
	endfunction
	function automatic int fb(input int i);
		return i < 4 ? 1 + 4 * (i % 2) + 2 * (i / 2) : eb(i);
	endfunction
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_vec(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t vector %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t value %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pw <= w;
		pa <= {2'b00, idx, 2'b00};
		pd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the bench-wide cycle ceiling ends a stuck wait
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		rd = prd;
		rs = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Enables go last so that the global bit opens the gate at once
	task automatic setcfg(input logic g);
		for (int k = 0; k < 3; k++)
			apb(1'b1, PI[k], {24'h0, pr[k]});
		for (int k = 2; k >= 0; k--)
			apb(1'b1, EI[k], {24'h0, (k == 0) ? {g, en[0][6:0]} : en[k]});
	endtask
	task automatic clrf();
		for (int k = 0; k < 3; k++)
			apb(1'b1, FI[k], 32'h0);
	endtask
	task automatic raise(input int i);
		@(posedge clk);
		src[i] <= 1'b1;
		if (i inside {0, 2, 4, 8})
			repeat (4) @(posedge clk);
		@(posedge clk);
		src[i] <= 1'b0;
		if (i inside {0, 2, 4, 8})
			repeat (4) @(posedge clk);
	endtask
	task automatic expect_call(input logic [15:0] e);
		int n;
		logic [15:0] v;
		n = 0;
		v = 'x;
		// Step past the edge so the branch logger has already run
		while (q.size() == 0 && n < 80) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (q.size() > 0)
			v = q.pop_front();
		chk_vec(v, e);
	endtask
	task automatic expect_none(input int n);
		repeat (n) @(posedge clk);
		#1;
		chk_val(32'(q.size()), 32'h0);
	endtask
	task automatic do_ret();
		@(posedge clk);
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		en = '{default: '0};
		pr = '{default: '0};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		expect_call(RESET_VEC);
		expect_none(4);
		apb(1'b0, EI[0], 32'h0);
		chk_val(rd, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk_val({31'h0, rs}, 32'h1);
		seed = xs(seed);
		apb(1'b1, EI[1], seed);
		apb(1'b0, EI[1], 32'h0);
		chk_val(rd, seed & 32'hfc);
		// A timer pulse while the clock enable is low must leave no flag behind
		@(posedge clk);
		ce <= 1'b0;
		src[1] <= 1'b1;
		@(posedge clk);
		src[1] <= 1'b0;
		ce <= 1'b1;
		apb(1'b0, FI[0], 32'h0);
		chk_val(rd, 32'h0);
		$display("test registers done");
		for (int i = 0; i < NSRC; i++) begin
			en = '{default: '0};
			en[grp(i)][eb(i)] = 1'b1;
			setcfg(1'b0);
			raise(i);
			expect_none(8);
			setcfg(1'b1);
			expect_call(VEC_TABLE[i]);
			chk_val({31'h0, wake}, {31'h0, i inside {0, 2, 4, 5, 9}});
			apb(1'b0, FI[grp(i)], 32'h0);
			chk_val({31'h0, rd[fb(i)]}, 32'h1);
			clrf();
			do_ret();
			chk_val({29'h0, lvl}, 32'h0);
		end
		$display("test vectors done");
		for (int k = 0; k < 6; k++) begin
			int a, b, c, w, l;
			seed = xs(seed);
			a = seed % 13;
			b = (a + 1 + seed[11:8] % 12) % 13;
			c = (b + 1) % 13 == a ? (a + 1) % 13 : (b + 1) % 13;
			w = (seed[4] != seed[5]) ? (seed[4] ? a : b) : (a < b ? a : b);
			l = (w == a) ? b : a;
			slow <= seed[20];
			en = '{default: '0};
			pr = '{default: '0};
			en[grp(a)][eb(a)] = 1'b1;
			en[grp(b)][eb(b)] = 1'b1;
			pr[grp(a)][eb(a)] = seed[4];
			pr[grp(b)][eb(b)] = seed[5];
			setcfg(1'b0);
			raise(a);
			raise(b);
			raise(c);
			setcfg(1'b1);
			expect_call(VEC_TABLE[w]);
			expect_none(10);
			apb(1'b1, FI[grp(w)], grp(l) == grp(w) ? 32'h1 << fb(l) : 32'h0);
			do_ret();
			expect_call(VEC_TABLE[l]);
			clrf();
			do_ret();
		end
		slow <= 1'b0;
		$display("test arbitration done");
		en = '{default: '0};
		pr = '{default: '0};
		en[0][3] = 1'b1;
		en[1][4] = 1'b1;
		pr[1][4] = 1'b1;
		en[2][2] = 1'b1;
		setcfg(1'b1);
		raise(3);
		expect_call(16'h001b);
		raise(12);
		expect_none(12);
		raise(6);
		expect_call(16'h005b);
		chk_val({29'h0, lvl}, 32'h3);
		apb(1'b1, IDX_XCFG, 32'h155);
		raise(13);
		expect_call(PDV);
		chk_val({29'h0, lvl}, 32'h7);
		apb(1'b1, IDX_XCFG, 32'h055);
		apb(1'b1, FI[1], 32'h0);
		do_ret();
		chk_val({29'h0, lvl}, 32'h3);
		apb(1'b1, FI[0], 32'h0);
		do_ret();
		expect_none(4);
		chk_val({29'h0, lvl}, 32'h1);
		do_ret();
		expect_call(16'h008b);
		clrf();
		do_ret();
		$display("test nesting done");
		wrap_up();
	end
endmodule
